// >>> inc/jtxll_map.vh
// register map, field positions and link characters of the tx link control
`ifndef JTXLL_MAP_VH
`define JTXLL_MAP_VH
`define JTXLL_CTRL_OFFS 4'h0
`define JTXLL_STAT_OFFS 4'h4
`define JTXLL_CTRL_RESET 32'h00000000
`define JTXLL_CTRL_WMASK 32'h0001FFFF
`define JTXLL_LANE_SYNC_BIT 0
`define JTXLL_ILAS_LEN_LSB 1
`define JTXLL_ILAS_LEN_MSB 8
`define JTXLL_REPL_DIS_BIT 9
`define JTXLL_LOOP_BIT 10
`define JTXLL_EXIT_SEL_BIT 11
`define JTXLL_SPARE_LSB 12
`define JTXLL_SPARE_MSB 16
`define JTXLL_ILAS_MIN_FIELD 8'h03
`define JTXLL_MIN_K_COUNT 3'h4
`define JTXLL_CHAR_CGS 8'hBC
`define JTXLL_CHAR_R 8'h1C
`define JTXLL_CHAR_Q 8'h9C
`define JTXLL_CHAR_A 8'h7C
`define JTXLL_CHAR_F 8'hFC
`define JTXLL_CFG_OCTETS 14
`define JTXLL_RESP_OKAY 2'h0
`define JTXLL_RESP_SLVERR 2'h2
`endif

// >>> logic/jtxll_lmfc.v
// local multiframe counter: octet position, frame and multiframe ends
`timescale 1ns/10ps
module jtxll_lmfc #(
    parameter F_OCTETS = 1,
    parameter K_FRAMES = 32,
    parameter POS_W = 12
) (
    input wire clk,
    input wire resetn,
    output wire [POS_W-1:0] pos,
    output wire frame_end,
    output wire mf_end
);
    localparam [POS_W-1:0] FRAME_LAST = F_OCTETS - 1;
    localparam [POS_W-1:0] MF_LAST = F_OCTETS * K_FRAMES - 1;
    reg [POS_W-1:0] pos_reg;
    reg [POS_W-1:0] oct_reg;

    assign pos = pos_reg;
    assign frame_end = (oct_reg == FRAME_LAST);
    assign mf_end = (pos_reg == MF_LAST);

    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pos_reg <= {POS_W{1'b0}};
            oct_reg <= {POS_W{1'b0}};
        end
        else
        begin
            pos_reg <= mf_end ? {POS_W{1'b0}} : pos_reg + 1'b1;
            oct_reg <= frame_end ? {POS_W{1'b0}} : oct_reg + 1'b1;
        end
    end
endmodule // jtxll_lmfc

// >>> logic/jtxll_top.v
// tx data link layer control: register, link state machine, octet stream
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/10ps
`include "jtxll_map.vh"
module jtxll_top #(
    parameter F_OCTETS = 1,
    parameter K_FRAMES = 32,
    parameter POS_W = 12,
    parameter [111:0] ILAS_CFG = 112'h0
) (
    input wire CLK_SYS,
    input wire RESETN,
    input wire [3:0] S_AWADDR,
    input wire S_AWVALID,
    output reg S_AWREADY,
    input wire [31:0] S_WDATA,
    input wire [3:0] S_WSTRB,
    input wire S_WVALID,
    output reg S_WREADY,
    output reg [1:0] S_BRESP,
    output reg S_BVALID,
    input wire S_BREADY,
    input wire [3:0] S_ARADDR,
    input wire S_ARVALID,
    output reg S_ARREADY,
    output reg [31:0] S_RDATA,
    output reg [1:0] S_RRESP,
    output reg S_RVALID,
    input wire S_RREADY,
    input wire LINK_REINIT,
    input wire SYNC_N,
    input wire [7:0] TX_USER_DATA,
    output reg [7:0] TX_OCTET,
    output reg TX_CHAR_K,
    output reg TX_USER_TAKEN,
    output reg [1:0] LINK_STATE
);
    localparam [1:0] ST_CGS = 2'h0;
    localparam [1:0] ST_ILAS = 2'h1;
    localparam [1:0] ST_DATA = 2'h2;
    localparam [POS_W-1:0] POS_Q = 1;
    localparam [POS_W-1:0] POS_CFG0 = 2;
    localparam [POS_W-1:0] POS_CFGN = 2 + `JTXLL_CFG_OCTETS;
    localparam [POS_W-1:0] POS_LAST = F_OCTETS * K_FRAMES - 1;

    wire [POS_W-1:0] pos;
    wire frame_end;
    wire mf_end;

    reg [31:0] ctrl_reg;
    reg [3:0] aw_addr_reg;
    reg aw_full_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;
    reg w_full_reg;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [2:0] k_cnt_reg;
    reg [7:0] mf_idx_reg;
    reg sync_q_reg;
    reg loop_q_reg;
    reg reinit_pend_reg;
    reg force_exit_reg;
    reg wait_rise_reg;
    reg rise_seen_reg;
    reg [7:0] prev_last_reg;

    wire lane_sync_en = ctrl_reg[`JTXLL_LANE_SYNC_BIT];
    wire repl_dis = ctrl_reg[`JTXLL_REPL_DIS_BIT];
    wire loop_en = ctrl_reg[`JTXLL_LOOP_BIT];
    wire exit_sel = ctrl_reg[`JTXLL_EXIT_SEL_BIT];
    wire [7:0] len_field = ctrl_reg[`JTXLL_ILAS_LEN_MSB:`JTXLL_ILAS_LEN_LSB];
    // last multiframe index of ILAS, never below the four multiframe minimum
    wire [7:0] ilas_last = (len_field < `JTXLL_ILAS_MIN_FIELD) ?
        `JTXLL_ILAS_MIN_FIELD : len_field;
    wire sync_rise = SYNC_N & ~sync_q_reg;
    wire loop_rise = loop_en & ~loop_q_reg;
    wire k_enough = (k_cnt_reg >= `JTXLL_MIN_K_COUNT);
    wire wr_fire = aw_full_reg & w_full_reg & ~S_BVALID;
    wire [31:0] wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}},
        {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
    wire [31:0] status = {20'h00000, mf_idx_reg, reinit_pend_reg,
        sync_q_reg, state_reg};
    wire cgs_exit;
    wire ilas_done;

    jtxll_lmfc #(
        .F_OCTETS(F_OCTETS),
        .K_FRAMES(K_FRAMES),
        .POS_W(POS_W)
    ) u_lmfc (
        .clk(CLK_SYS),
        .resetn(RESETN),
        .pos(pos),
        .frame_end(frame_end),
        .mf_end(mf_end)
    );

    // write channel: address and data taken in either order
    always @(posedge CLK_SYS or negedge RESETN)
    begin
        if (!RESETN)
        begin
            S_AWREADY <= 1'b1;
            S_WREADY <= 1'b1;
            S_BVALID <= 1'b0;
            S_BRESP <= `JTXLL_RESP_OKAY;
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            aw_addr_reg <= 4'h0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
            ctrl_reg <= `JTXLL_CTRL_RESET;
        end
        else
        begin
            if (S_AWVALID && S_AWREADY)
            begin
                aw_addr_reg <= S_AWADDR;
                aw_full_reg <= 1'b1;
                S_AWREADY <= 1'b0;
            end
            if (S_WVALID && S_WREADY)
            begin
                w_data_reg <= S_WDATA;
                w_strb_reg <= S_WSTRB;
                w_full_reg <= 1'b1;
                S_WREADY <= 1'b0;
            end
            if (wr_fire)
            begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                S_BVALID <= 1'b1;
                if (aw_addr_reg[3:2] == `JTXLL_CTRL_OFFS >> 2)
                begin
                    // reserved upper bits never stored
                    ctrl_reg <= ((ctrl_reg & ~wmask) | (w_data_reg & wmask))
                        & `JTXLL_CTRL_WMASK;
                    S_BRESP <= `JTXLL_RESP_OKAY;
                end
                else
                begin
                    S_BRESP <= `JTXLL_RESP_SLVERR;
                end
            end
            if (S_BVALID && S_BREADY)
            begin
                S_BVALID <= 1'b0;
                S_AWREADY <= 1'b1;
                S_WREADY <= 1'b1;
            end
        end
    end

    // read channel
    always @(posedge CLK_SYS or negedge RESETN)
    begin
        if (!RESETN)
        begin
            S_ARREADY <= 1'b1;
            S_RVALID <= 1'b0;
            S_RDATA <= 32'h00000000;
            S_RRESP <= `JTXLL_RESP_OKAY;
        end
        else if (S_ARVALID && S_ARREADY)
        begin
            S_ARREADY <= 1'b0;
            S_RVALID <= 1'b1;
            if (S_ARADDR[3:2] == `JTXLL_CTRL_OFFS >> 2)
            begin
                S_RDATA <= ctrl_reg;
                S_RRESP <= `JTXLL_RESP_OKAY;
            end
            else if (S_ARADDR[3:2] == `JTXLL_STAT_OFFS >> 2)
            begin
                S_RDATA <= status;
                S_RRESP <= `JTXLL_RESP_OKAY;
            end
            else
            begin
                S_RDATA <= 32'h00000000;
                S_RRESP <= `JTXLL_RESP_SLVERR;
            end
        end
        else if (S_RVALID && S_RREADY)
        begin
            S_RVALID <= 1'b0;
            S_ARREADY <= 1'b1;
        end
    end

    // CGS leaves only on a multiframe end after four K28.5
    assign cgs_exit = mf_end && k_enough &&
        (force_exit_reg ? 1'b1 :
         wait_rise_reg ? rise_seen_reg : SYNC_N);
    assign ilas_done = mf_end && (mf_idx_reg == ilas_last);

    always @*
    begin
        state_next = state_reg;
        case (state_reg)
            ST_CGS:
            begin
                if (cgs_exit)
                begin
                    state_next = (lane_sync_en || loop_en) ?
                        ST_ILAS : ST_DATA;
                end
            end
            ST_ILAS:
            begin
                if (!SYNC_N || loop_rise)
                begin
                    state_next = ST_CGS;
                end
                else if (ilas_done && !loop_en)
                begin
                    state_next = ST_DATA;
                end
            end
            ST_DATA:
            begin
                if (!SYNC_N || loop_rise)
                begin
                    state_next = ST_CGS;
                end
            end
            default:
            begin
                state_next = ST_CGS;
            end
        endcase
        if (LINK_REINIT)
        begin
            state_next = ST_CGS;
        end
    end

    // link state and CGS exit mode
    always @(posedge CLK_SYS or negedge RESETN)
    begin
        if (!RESETN)
        begin
            state_reg <= ST_CGS;
            k_cnt_reg <= 3'h0;
            mf_idx_reg <= 8'h00;
            sync_q_reg <= 1'b0;
            loop_q_reg <= 1'b0;
            reinit_pend_reg <= 1'b0;
            force_exit_reg <= 1'b0;
            wait_rise_reg <= 1'b0;
            rise_seen_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            sync_q_reg <= SYNC_N;
            loop_q_reg <= loop_en;
            if (state_next != ST_CGS)
            begin
                k_cnt_reg <= 3'h0;
            end
            else if (state_reg == ST_CGS && !k_enough)
            begin
                k_cnt_reg <= k_cnt_reg + 3'h1;
            end
            if (state_reg != ST_ILAS || ilas_done)
            begin
                mf_idx_reg <= 8'h00;
            end
            else if (mf_end)
            begin
                mf_idx_reg <= mf_idx_reg + 8'h01;
            end
            if (state_reg == ST_CGS && cgs_exit)
            begin
                reinit_pend_reg <= 1'b0;
                force_exit_reg <= 1'b0;
                wait_rise_reg <= 1'b0;
                rise_seen_reg <= 1'b0;
            end
            else if (sync_rise && wait_rise_reg)
            begin
                rise_seen_reg <= 1'b1;
            end
            if (LINK_REINIT)
            begin
                // set wins over the exit clear above
                reinit_pend_reg <= 1'b1;
                force_exit_reg <= ~exit_sel;
                wait_rise_reg <= exit_sel;
                rise_seen_reg <= 1'b0;
                k_cnt_reg <= 3'h0;
            end
            else if (loop_rise && state_reg != ST_CGS)
            begin
                force_exit_reg <= SYNC_N;
                wait_rise_reg <= 1'b0;
                k_cnt_reg <= 3'h0;
            end
        end
    end

    // octet stream
    always @(posedge CLK_SYS or negedge RESETN)
    begin
        if (!RESETN)
        begin
            TX_OCTET <= 8'h00;
            TX_CHAR_K <= 1'b0;
            TX_USER_TAKEN <= 1'b0;
            LINK_STATE <= ST_CGS;
            prev_last_reg <= 8'h00;
        end
        else
        begin
            LINK_STATE <= state_reg;
            TX_USER_TAKEN <= (state_reg == ST_DATA);
            case (state_reg)
                ST_CGS:
                begin
                    TX_OCTET <= `JTXLL_CHAR_CGS;
                    TX_CHAR_K <= 1'b1;
                end
                ST_ILAS:
                begin
                    if (pos == {POS_W{1'b0}})
                    begin
                        TX_OCTET <= `JTXLL_CHAR_R;
                        TX_CHAR_K <= 1'b1;
                    end
                    else if (pos == POS_LAST)
                    begin
                        TX_OCTET <= `JTXLL_CHAR_A;
                        TX_CHAR_K <= 1'b1;
                    end
                    else if (mf_idx_reg == 8'h01 && pos == POS_Q)
                    begin
                        TX_OCTET <= `JTXLL_CHAR_Q;
                        TX_CHAR_K <= 1'b1;
                    end
                    else if (mf_idx_reg == 8'h01 && pos >= POS_CFG0 &&
                        pos < POS_CFGN)
                    begin
                        TX_OCTET <= ILAS_CFG[(pos - POS_CFG0) * 8 +: 8];
                        TX_CHAR_K <= 1'b0;
                    end
                    else
                    begin
                        TX_OCTET <= pos[7:0];
                        TX_CHAR_K <= 1'b0;
                    end
                end
                ST_DATA:
                begin
                    if (frame_end)
                    begin
                        prev_last_reg <= TX_USER_DATA;
                    end
                    if (frame_end && !repl_dis &&
                        TX_USER_DATA == prev_last_reg)
                    begin
                        TX_OCTET <= (mf_end && lane_sync_en) ?
                            `JTXLL_CHAR_A : `JTXLL_CHAR_F;
                        TX_CHAR_K <= 1'b1;
                    end
                    else
                    begin
                        TX_OCTET <= TX_USER_DATA;
                        TX_CHAR_K <= 1'b0;
                    end
                end
                default:
                begin
                    TX_OCTET <= 8'h00;
                    TX_CHAR_K <= 1'b0;
                end
            endcase
        end
    end
endmodule // jtxll_top

// >>> tb/jtxll_props.sv
// port checks for the tx link control
`timescale 1ns/10ps
module jtxll_props (
    input wire CLK_SYS,
    input wire RESETN,
    input wire S_AWVALID,
    input wire S_AWREADY,
    input wire S_WVALID,
    input wire S_WREADY,
    input wire S_BVALID,
    input wire S_ARVALID,
    input wire S_ARREADY,
    input wire [31:0] S_RDATA,
    input wire S_RVALID,
    input wire SYNC_N,
    input wire [7:0] TX_OCTET,
    input wire TX_CHAR_K,
    input wire TX_USER_TAKEN,
    input wire [1:0] LINK_STATE
);
    default clocking dc @(posedge CLK_SYS);
    endclocking
    default disable iff (!RESETN);
    property p_cgs_char;
        $past(RESETN) && LINK_STATE == 2'h0 && $past(LINK_STATE) == 2'h0
            |-> TX_OCTET == 8'hBC && TX_CHAR_K;
    endproperty
    a_cgs_char: assert property (p_cgs_char)
        else $error("cgs octet wrong");
    property p_min_k;
        LINK_STATE != 2'h0 && $past(LINK_STATE) == 2'h0
            |-> $past(LINK_STATE, 2) == 2'h0 && $past(LINK_STATE, 3) == 2'h0
            && $past(LINK_STATE, 4) == 2'h0;
    endproperty
    a_min_k: assert property (p_min_k)
        else $error("cgs left too early");
    property p_cgs_exit;
        LINK_STATE == 2'h1 && $past(LINK_STATE) == 2'h0
            |-> TX_OCTET == 8'h1C && TX_CHAR_K;
    endproperty
    a_cgs_exit: assert property (p_cgs_exit)
        else $error("ilas not started at boundary");
    property p_sync_loss;
        LINK_STATE != 2'h0 && !SYNC_N |-> ##[1:3] LINK_STATE == 2'h0;
    endproperty
    a_sync_loss: assert property (p_sync_loss)
        else $error("no return to cgs");
    property p_taken;
        TX_USER_TAKEN |-> LINK_STATE == 2'h2;
    endproperty
    a_taken: assert property (p_taken)
        else $error("user data taken outside data state");
    property p_bresp;
        S_AWVALID && S_AWREADY && S_WVALID && S_WREADY |-> ##[1:2] S_BVALID;
    endproperty
    a_bresp: assert property (p_bresp)
        else $error("write response late");
    property p_ar;
        S_ARVALID && S_ARREADY |=> S_RVALID && !S_ARREADY;
    endproperty
    a_ar: assert property (p_ar)
        else $error("read answer late");
    property p_rd_hi;
        S_RVALID |-> S_RDATA[31:17] == 15'h0;
    endproperty
    a_rd_hi: assert property (p_rd_hi)
        else $error("upper read bits set");
    property p_bwait;
        S_BVALID |-> !S_AWREADY && !S_WREADY;
    endproperty
    a_bwait: assert property (p_bwait)
        else $error("write taken during response");
endmodule // jtxll_props
bind jtxll_top jtxll_props jtxll_props_i (.CLK_SYS(CLK_SYS),
    .RESETN(RESETN), .S_AWVALID(S_AWVALID), .S_AWREADY(S_AWREADY),
    .S_WVALID(S_WVALID), .S_WREADY(S_WREADY), .S_BVALID(S_BVALID),
    .S_ARVALID(S_ARVALID), .S_ARREADY(S_ARREADY), .S_RDATA(S_RDATA),
    .S_RVALID(S_RVALID), .SYNC_N(SYNC_N), .TX_OCTET(TX_OCTET),
    .TX_CHAR_K(TX_CHAR_K), .TX_USER_TAKEN(TX_USER_TAKEN),
    .LINK_STATE(LINK_STATE));

// >>> tb/jtxll_dac.sv
// converter model: holds sync request, releases after four K28.5
`timescale 1ns/10ps
module jtxll_dac (
    input wire clk,
    input wire resetn,
    input wire [7:0] octet,
    input wire char_k,
    input wire hold,
    output reg sync_n
);
    reg [2:0] k_cnt;
    wire is_k = char_k && octet == 8'hBC;
    always @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sync_n <= 1'b0;
            k_cnt <= 3'h0;
        end
        else
        begin
            k_cnt <= (hold || !is_k) ? 3'h0 : k_cnt + 3'h1;
            if (hold)
                sync_n <= 1'b0;
            else if (is_k && k_cnt == 3'h3)
                sync_n <= 1'b1;
        end
    end
endmodule // jtxll_dac

// >>> tb/jtxll_top_bench.sv
// bench of the tx link control against a converter model
`timescale 1ns/10ps
module jtxll_top_bench;
    reg clk, rst_n, awv, wv, bry, arv, rry, reinit, hold, chk_en, ev, pv;
    reg [3:0] awa, ara, ws;
    reg [31:0] wd, ctrl, lfsr;
    reg [7:0] ud, prv;
    reg [8:0] ex;
    wire awr, wrd, bv, arr, rv, sync_n, k, tk;
    wire [1:0] br, rr, ls;
    wire [31:0] rdat;
    wire [7:0] oct;
    integer mismatches, cmp_count, n, m, f, ps;
    jtxll_top jtxll_top_i (.CLK_SYS(clk), .RESETN(rst_n),
        .S_AWADDR(awa), .S_AWVALID(awv), .S_AWREADY(awr),
        .S_WDATA(wd), .S_WSTRB(ws), .S_WVALID(wv), .S_WREADY(wrd),
        .S_BRESP(br), .S_BVALID(bv), .S_BREADY(bry),
        .S_ARADDR(ara), .S_ARVALID(arv), .S_ARREADY(arr),
        .S_RDATA(rdat), .S_RRESP(rr), .S_RVALID(rv), .S_RREADY(rry),
        .LINK_REINIT(reinit), .SYNC_N(sync_n), .TX_USER_DATA(ud),
        .TX_OCTET(oct), .TX_CHAR_K(k), .TX_USER_TAKEN(tk),
        .LINK_STATE(ls));
    jtxll_dac jtxll_dac_i (.clk(clk), .resetn(rst_n), .octet(oct),
        .char_k(k), .hold(hold), .sync_n(sync_n));
    function [31:0] nxt(input [31:0] s);
        nxt = (s >> 1) ^ (s[0] ? 32'h80200003 : 32'h0);
    endfunction
    task cmp(input [31:0] got, input [31:0] exp);
    begin
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            mismatches = mismatches + 1;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    end
    endtask
    task wr(input [3:0] a, input [31:0] d, input [1:0] r);
        reg ad, dd;
    begin
        ad = 1'b0;
        dd = 1'b0;
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        while (!(ad && dd))
        begin
            @(posedge clk);
            ad = ad | awr;
            dd = dd | wrd;
            if (ad)
                awv <= 1'b0;
            if (dd)
                wv <= 1'b0;
        end
        while (!bv)
            @(posedge clk);
        cmp({30'h0, br}, {30'h0, r});
        bry <= 1'b0;
        @(posedge clk);
    end
    endtask
    task rd(input [3:0] a, input [31:0] e, input [1:0] r);
    begin
        ara <= a;
        arv <= 1'b1;
        rry <= 1'b1;
        @(posedge clk);
        while (!arr)
            @(posedge clk);
        arv <= 1'b0;
        while (!rv)
            @(posedge clk);
        cmp(rdat, e);
        cmp({30'h0, rr}, {30'h0, r});
        rry <= 1'b0;
        @(posedge clk);
    end
    endtask
    task wc(input [31:0] d);
    begin
        chk_en = 1'b0;
        wr(4'h0, d, 2'h0);
        ctrl = d;
    end
    endtask
    task wst(input [1:0] s, input integer lim);
    begin
        n = 0;
        while (ls !== s && n < lim)
        begin
            @(posedge clk);
            n = n + 1;
        end
        cmp({30'h0, ls}, {30'h0, s});
    end
    endtask
    // ilas cycles into n, start-of-multiframe marks into m
    task span(input integer c);
    begin
        n = 0;
        m = 0;
        repeat (c)
        begin
            @(posedge clk);
            n = n + ((ls === 2'h1) ? 1 : 0);
            m = m + ((k === 1'b1 && oct === 8'h1C) ? 1 : 0);
        end
    end
    endtask
    task pulse;
    begin
        reinit <= 1'b1;
        @(posedge clk);
        reinit <= 1'b0;
    end
    endtask
    task final_report;
    begin
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    end
    endtask
    // user octets with frequent repeats to provoke replacement
    always @(posedge clk)
    begin
        lfsr <= nxt(lfsr);
        if (lfsr[1:0] != 2'h0)
            ud <= lfsr[9:2];
        ev <= tk && pv && chk_en;
        // multiframe end with lane sync on takes /A/, otherwise /F/
        ex <= (!ctrl[9] && ud === prv) ?
            ((ps == 31 && ctrl[0]) ? 9'h17C : 9'h1FC) : {1'b0, ud};
        ps <= (!rst_n || ps == 31) ? 0 : ps + 1;
        prv <= ud;
        pv <= tk;
    end
    always @(negedge clk)
        if (ev)
            cmp({23'h0, k, oct}, {23'h0, ex});
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial
    begin
        #(20000 * 100);
        mismatches = mismatches + 1;
        final_report;
    end
    initial
    begin
        {awv, wv, bry, arv, rry, reinit, hold, chk_en, ev, pv} = 10'h0;
        {awa, ara, wd, ctrl, ud, prv, ex} = 97'h0;
        ws = 4'hF;
        ps = 0;
        lfsr = 32'hBA6F;
        mismatches = 0;
        cmp_count = 0;
        rst_n = 1'b0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(4'h0, 32'h0, 2'h0);
        rd(4'h8, 32'h0, 2'h2);
        wr(4'hC, 32'hFFFFFFFF, 2'h2);
        wr(4'h4, 32'h1, 2'h2);
        wc({lfsr[31:12], 12'h000});
        rd(4'h0, {15'h0, ctrl[16:12], 12'h0}, 2'h0);
        ws <= 4'h4;
        wr(4'h0, 32'hFFFFFFFF, 2'h0);
        ws <= 4'hF;
        rd(4'h0, {15'h0, 1'b1, ctrl[15:12], 12'h0}, 2'h0);
        $display("test regs done");
        pulse;
        span(100);
        cmp(n, 0);
        cmp({30'h0, ls}, 32'h2);
        chk_en = 1'b1;
        repeat (200) @(posedge clk);
        wc(ctrl | 32'h200);
        chk_en = 1'b1;
        repeat (200) @(posedge clk);
        $display("test replace done");
        for (f = 0; f < 6; f = f + 1)
        begin
            wc({23'h0, f[7:0], 1'b1});
            pulse;
            wst(2'h1, 60);
            n = 0;
            while (ls === 2'h1 && n < 9000)
            begin
                @(posedge clk);
                n = n + 1;
            end
            cmp(n, ((f < 3) ? 4 : f + 1) * 32);
        end
        chk_en = 1'b1;
        repeat (640) @(posedge clk);
        chk_en = 1'b0;
        $display("test length done");
        hold <= 1'b1;
        wst(2'h0, 10);
        pulse;
        wst(2'h1, 60);
        wc(32'h807);
        pulse;
        span(100);
        cmp(n, 0);
        hold <= 1'b0;
        wst(2'h1, 48);
        wst(2'h2, 200);
        $display("test exit done");
        wc(32'hC07);
        wst(2'h0, 20);
        wst(2'h1, 48);
        span(320);
        cmp(n, 320);
        cmp(m, 10);
        hold <= 1'b1;
        wst(2'h0, 10);
        hold <= 1'b0;
        wst(2'h1, 48);
        span(64);
        cmp(n, 64);
        hold <= 1'b1;
        wc(32'h807);
        wc(32'hC07);
        span(100);
        cmp(n, 0);
        hold <= 1'b0;
        wst(2'h1, 48);
        span(64);
        cmp(n, 64);
        $display("test loop done");
        final_report;
    end
endmodule // jtxll_top_bench
